// ===== core/rsp_pkg.sv
// Shared constants and types of the run/stop power-up selector.
// Assumes a single 125 MHz system clock domain.
package rsp_pkg;

	// ********************
	// Selections
	// ********************
	typedef enum logic [1:0] {
		RSP_PWR_KEEP = 2'b00,
		RSP_PWR_RUN = 2'b01,
		RSP_PWR_STOP = 2'b10
	} rsp_pwr_sel_e;

	typedef enum logic {
		RSP_BK_RUN = 1'b0,
		RSP_BK_STOP = 1'b1
	} rsp_bk_sel_e;

	typedef enum logic [1:0] {
		RSP_ST_SETTLE = 2'b00,
		RSP_ST_DECIDE = 2'b01,
		RSP_ST_RUN = 2'b10,
		RSP_ST_STOP = 2'b11
	} rsp_state_e;

	// ********************
	// Reset values and timing
	// ********************
	localparam logic [1:0] RSP_CFG_PWR_RST = 2'h0;
	localparam logic RSP_CFG_BK_RST = 1'h0;
	localparam logic RSP_CFG_DESIG_RST = 1'h0;
	localparam logic [2:0] RSP_SETTLE_CYC = 3'h5;
	localparam int RSP_SYNC_W = 3;

endpackage

// ===== core/rsp_retain.sv
// Retained one-bit store for the start control relay.
// Sits on the backup supply: it has no reset, so its content outlives rst_n.
`timescale 1ns/1ps
`default_nettype none
module rsp_retain
(
	// Clock
	input wire logic clk_sys,
	// Write side
	input wire logic wr_en,
	input wire logic wr_bit,
	// Read side
	output logic rd_bit
);

	logic store_q;

	// No reset on purpose: a reset would wipe the retained value
	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			store_q <= wr_bit;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		rd_bit <= store_q;
	end

endmodule
`default_nettype wire

// ===== core/rsp_run_stop.sv
// Run/stop decision at power-up and during operation.
// Assumes rst_n marks each power-up; pins are asynchronous, host strobes synchronous.
`timescale 1ns/1ps
`default_nettype none
module rsp_run_stop
	import rsp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Selections from the host, staged until download
	input wire logic [1:0] pwr_sel,
	input wire logic bk_sel,
	input wire logic stop_desig,
	input wire logic reset_desig,
	input wire logic prog_load,
	// Host commands
	input wire logic start_cmd,
	input wire logic stop_cmd,
	// Pins
	input wire logic stop_in,
	input wire logic reset_in,
	input wire logic backup_lost,
	input wire logic cart_fitted,
	// Status
	output logic run_o,
	output logic start_control_relay,
	output logic backup_err,
	output logic [1:0] state_o
);
	import rsp_pkg::*;

	// ********************
	// State
	// ********************
	typedef struct packed {
		rsp_state_e st;
		logic [2:0] cnt;
		logic relay;
		logic flag;
		logic run;
		logic [1:0] cfg_pwr;
		logic cfg_bk;
		logic cfg_stop_en;
		logic cfg_rst_en;
		logic [RSP_SYNC_W-1:0] sync_stop;
		logic [RSP_SYNC_W-1:0] sync_rst;
		logic [RSP_SYNC_W-1:0] sync_bat;
		logic stop_f;
		logic rst_f;
		logic bat_f;
	} rsp_state_s;

	rsp_state_s s_q;
	rsp_state_s s_d;
	logic ret_wr_en;
	logic ret_wr_bit;
	logic ret_rd_bit;
	logic halt;
	logic decided;

	// ********************
	// Retained relay
	// ********************
	rsp_retain u_retain
	(
		.clk_sys(clk_sys),
		.wr_en(ret_wr_en),
		.wr_bit(ret_wr_bit),
		.rd_bit(ret_rd_bit)
	);

	// Designated inputs only; undesignated pins are ignored
	assign halt = (s_q.cfg_stop_en & s_q.stop_f) | (s_q.cfg_rst_en & s_q.rst_f);

	// Cartridge presence never enters the decision
	logic cart_unused;
	assign cart_unused = cart_fitted;

	// ********************
	// Next state
	// ********************
	always_comb
	begin
		s_d = s_q;
		ret_wr_en = 1'b0;
		ret_wr_bit = s_q.relay;
		decided = s_q.relay;

		// Three-stage sync; a change counts once stages two and three agree
		s_d.sync_stop = {s_q.sync_stop[1:0], stop_in};
		s_d.sync_rst = {s_q.sync_rst[1:0], reset_in};
		s_d.sync_bat = {s_q.sync_bat[1:0], backup_lost};
		if (s_q.sync_stop[1] == s_q.sync_stop[2])
		begin
			s_d.stop_f = s_q.sync_stop[2];
		end
		if (s_q.sync_rst[1] == s_q.sync_rst[2])
		begin
			s_d.rst_f = s_q.sync_rst[2];
		end
		if (s_q.sync_bat[1] == s_q.sync_bat[2])
		begin
			s_d.bat_f = s_q.sync_bat[2];
		end

		// Selections are staged and take effect on download
		if (prog_load)
		begin
			s_d.cfg_pwr = pwr_sel;
			s_d.cfg_bk = bk_sel;
			s_d.cfg_stop_en = stop_desig;
			s_d.cfg_rst_en = reset_desig;
		end

		unique case (s_q.st)
			RSP_ST_SETTLE:
			begin
				// Let the pin filters fill before judging the backup state
				s_d.run = 1'b0;
				s_d.cnt = s_q.cnt + 3'h1;
				if (s_q.cnt == RSP_SETTLE_CYC)
				begin
					s_d.st = RSP_ST_DECIDE;
				end
			end
			RSP_ST_DECIDE:
			begin
				if (s_q.bat_f)
				begin
					s_d.flag = 1'b1;
					decided = (s_q.cfg_bk == RSP_BK_RUN);
				end
				else
				begin
					s_d.flag = 1'b0;
					if (s_q.cfg_pwr == RSP_PWR_RUN)
					begin
						decided = 1'b1;
					end
					else if (s_q.cfg_pwr == RSP_PWR_STOP)
					begin
						decided = 1'b0;
					end
					else
					begin
						// Unused code behaves as keep
						decided = ret_rd_bit;
					end
				end
				ret_wr_en = 1'b1;
				ret_wr_bit = decided;
				s_d.relay = decided;
				s_d.run = decided & ~halt;
				s_d.st = (decided & ~halt) ? RSP_ST_RUN : RSP_ST_STOP;
			end
			RSP_ST_RUN, RSP_ST_STOP:
			begin
				// Stop command wins if both arrive together
				if (stop_cmd)
				begin
					decided = 1'b0;
				end
				else if (start_cmd)
				begin
					decided = 1'b1;
				end
				ret_wr_en = start_cmd | stop_cmd;
				ret_wr_bit = decided;
				s_d.relay = decided;
				s_d.run = decided & ~halt;
				s_d.st = (decided & ~halt) ? RSP_ST_RUN : RSP_ST_STOP;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '{st: RSP_ST_SETTLE, cnt: 3'h0, relay: 1'b0, flag: 1'b0, run: 1'b0,
				cfg_pwr: RSP_CFG_PWR_RST, cfg_bk: RSP_CFG_BK_RST,
				cfg_stop_en: RSP_CFG_DESIG_RST, cfg_rst_en: RSP_CFG_DESIG_RST,
				sync_stop: '0, sync_rst: '0, sync_bat: '0,
				stop_f: 1'b0, rst_f: 1'b0, bat_f: 1'b0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ********************
	// Outputs
	// ********************
	assign run_o = s_q.run;
	assign start_control_relay = s_q.relay;
	assign backup_err = s_q.flag;
	assign state_o = s_q.st;

	// ********************
	// Checks
	// ********************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_halt_forces_stop: assert property (halt |=> !run_o)
		else $error("run while designated stop or reset input active");

	a_keep_follows: assert property ((s_q.st == RSP_ST_DECIDE && !s_q.bat_f
		&& s_q.cfg_pwr == RSP_PWR_KEEP) |=> start_control_relay == $past(ret_rd_bit))
		else $error("keep selection did not follow retained relay");

	a_force_run: assert property ((s_q.st == RSP_ST_DECIDE && !s_q.bat_f
		&& s_q.cfg_pwr == RSP_PWR_RUN && !halt) |=> start_control_relay && run_o)
		else $error("forced run did not start");

	a_force_stop: assert property ((s_q.st == RSP_ST_DECIDE && !s_q.bat_f
		&& s_q.cfg_pwr == RSP_PWR_STOP) |=> !start_control_relay && state_o == RSP_ST_STOP)
		else $error("forced stop did not stop");

	a_bkerr_run: assert property ((s_q.st == RSP_ST_DECIDE && s_q.bat_f
		&& s_q.cfg_bk == RSP_BK_RUN && !halt) |=> run_o && backup_err)
		else $error("backup error with run selection did not run");

	a_bkerr_stop: assert property ((s_q.st == RSP_ST_DECIDE && s_q.bat_f
		&& s_q.cfg_bk == RSP_BK_STOP) |=> !run_o ##1 !run_o || $past(start_cmd))
		else $error("backup error with stop selection started");

	a_start_cmd: assert property ((state_o == RSP_ST_STOP && start_cmd && !stop_cmd
		&& !halt) |=> run_o && start_control_relay)
		else $error("start command did not leave stop");

	a_flag_sticky: assert property ((backup_err && s_q.st != RSP_ST_DECIDE)
		|=> backup_err)
		else $error("backup error flag dropped outside power-up");

	a_cfg_staged: assert property ((!prog_load) |=> s_q.cfg_pwr == $past(s_q.cfg_pwr)
		&& s_q.cfg_bk == $past(s_q.cfg_bk))
		else $error("selection changed without download");

	a_settle_len: assert property ($rose(rst_n) |-> (state_o == RSP_ST_SETTLE) [*6]
		##1 state_o == RSP_ST_DECIDE)
		else $error("power-up settle length wrong");

	// ********************
	// Power-up and operation bookkeeping checks
	// ********************
	// The flag must track the filtered battery monitor at every decide
	a_flag_set: assert property ((s_q.st == RSP_ST_DECIDE && s_q.bat_f) |=> backup_err)
		else $error("backup error not flagged at power-up");

	a_flag_clear: assert property ((s_q.st == RSP_ST_DECIDE && !s_q.bat_f)
		|=> !backup_err)
		else $error("backup error flag kept after clean power-up");

	// Store is read through a register, so the written value shows two edges on
	a_retain_write: assert property ((s_q.st == RSP_ST_DECIDE)
		|=> ##1 ret_rd_bit == $past(start_control_relay))
		else $error("decided relay value not retained");

	// A held pin must not wipe the relay, or run could not resume on release
	a_halt_keeps_relay: assert property ((halt && s_q.st[1] && !start_cmd && !stop_cmd)
		|=> start_control_relay == $past(start_control_relay))
		else $error("halt changed the relay");

	a_stop_cmd: assert property ((s_q.st[1] && stop_cmd)
		|=> !run_o && !start_control_relay)
		else $error("stop command did not stop");

	a_run_needs_relay: assert property (run_o |-> start_control_relay)
		else $error("running with relay off");

	a_settle_idle: assert property ((state_o == RSP_ST_SETTLE) |-> !run_o
		&& !start_control_relay)
		else $error("running or relay set during settle");

	a_decide_once: assert property ((state_o == RSP_ST_DECIDE)
		|=> state_o == RSP_ST_RUN || state_o == RSP_ST_STOP)
		else $error("decide state lasted more than one cycle");

endmodule
`default_nettype wire

// ===== verif/rsp_far_side.sv
// Far-side model: programming host and the stop, reset and battery pins.
// Assumes one caller thread; host changes land 1 ns after a clk_sys edge, pin changes land when pins is called.
`timescale 1ns/1ps
`default_nettype none
module rsp_far_side
(
	// Clock
	input wire logic clk_sys,
	// Host
	output logic [1:0] pwr_sel,
	output logic bk_sel,
	output logic stop_desig,
	output logic reset_desig,
	output logic prog_load,
	output logic start_cmd,
	output logic stop_cmd,
	// Pins
	output logic stop_in,
	output logic reset_in,
	output logic backup_lost
);
	initial
	begin
		{pwr_sel, bk_sel, stop_desig, reset_desig, prog_load, start_cmd, stop_cmd} = 8'h00;
		{stop_in, reset_in, backup_lost} = 3'h0;
	end
	// New selections only count once downloaded
	task automatic load(input logic [1:0] p, input logic b, input logic s, input logic r);
		@(posedge clk_sys);
		#1;
		{pwr_sel, bk_sel, stop_desig, reset_desig} = {p, b, s, r};
		prog_load = 1'b1;
		@(posedge clk_sys);
		#1;
		prog_load = 1'b0;
	endtask
	task automatic start();
		@(posedge clk_sys);
		#1;
		start_cmd = 1'b1;
		@(posedge clk_sys);
		#1;
		start_cmd = 1'b0;
	endtask
	task automatic stop();
		@(posedge clk_sys);
		#1;
		stop_cmd = 1'b1;
		@(posedge clk_sys);
		#1;
		stop_cmd = 1'b0;
	endtask
	task automatic pins(input logic s, input logic r, input logic l);
		{stop_in, reset_in, backup_lost} = {s, r, l};
	endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the run/stop power-up selector.
// Assumes rsp_far_side plays host and pins; each rst_n release is a power-up.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rsp_pkg::*;
	logic clk_sys, rst_n, cart_fitted, run_o, start_control_relay, backup_err;
	logic [1:0] pwr_sel, state_o;
	logic bk_sel, stop_desig, prog_load, start_cmd, stop_in, reset_in, backup_lost;
	logic reset_desig, stop_cmd;
	int err_total;
	int checks;
	rsp_far_side far (.clk_sys(clk_sys), .pwr_sel(pwr_sel), .bk_sel(bk_sel),
		.stop_desig(stop_desig), .reset_desig(reset_desig), .prog_load(prog_load),
		.start_cmd(start_cmd), .stop_cmd(stop_cmd),
		.stop_in(stop_in), .reset_in(reset_in), .backup_lost(backup_lost));
	rsp_run_stop dut (.clk_sys(clk_sys), .rst_n(rst_n), .pwr_sel(pwr_sel), .bk_sel(bk_sel),
		.stop_desig(stop_desig), .reset_desig(reset_desig), .prog_load(prog_load),
		.start_cmd(start_cmd), .stop_cmd(stop_cmd), .stop_in(stop_in), .reset_in(reset_in),
		.backup_lost(backup_lost), .cart_fitted(cart_fitted), .run_o(run_o),
		.start_control_relay(start_control_relay), .backup_err(backup_err),
		.state_o(state_o));
	// ********************
	// Checking and closing
	// ********************
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %b expected %b", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic judge(input logic r, input logic c, input logic e);
		check(run_o, r);
		check(start_control_relay, c);
		check(backup_err, e);
	endtask
	// ********************
	// Power-up sequence
	// ********************
	task automatic power_up(input logic [1:0] p, input logic b, input logic lost);
		int n;
		rst_n = 1'b0;
		far.pins(1'b0, 1'b0, lost);
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		far.load(p, b, 1'b0, 1'b0);
		n = 0;
		while (state_o[1] !== 1'b1 && n < 50)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n == 50)
		begin
			err_total++;
			summarize();
		end
		@(posedge clk_sys);
		#1;
	endtask
	// ********************
	// Scenarios
	// ********************
	task automatic sc_forced();
		power_up(2'h1, 1'b0, 1'b0);
		judge(1'b1, 1'b1, 1'b0);
		check(state_o, RSP_ST_RUN);
		power_up(2'h2, 1'b0, 1'b0);
		judge(1'b0, 1'b0, 1'b0);
		check(state_o, RSP_ST_STOP);
	endtask
	task automatic sc_keep();
		power_up(2'h1, 1'b0, 1'b0);
		cart_fitted = 1'b1;
		power_up(2'h0, 1'b0, 1'b0);
		judge(1'b1, 1'b1, 1'b0);
		power_up(2'h2, 1'b0, 1'b0);
		power_up(2'h3, 1'b0, 1'b0);
		judge(1'b0, 1'b0, 1'b0);
		cart_fitted = 1'b0;
	endtask
	task automatic sc_backup();
		power_up(2'h1, 1'b1, 1'b1);
		judge(1'b0, 1'b0, 1'b1);
		far.start();
		@(posedge clk_sys);
		#1;
		judge(1'b1, 1'b1, 1'b1);
		power_up(2'h2, 1'b0, 1'b1);
		judge(1'b1, 1'b1, 1'b1);
		power_up(2'h1, 1'b0, 1'b0);
		judge(1'b1, 1'b1, 1'b0);
	endtask
	task automatic sc_pins();
		power_up(2'h1, 1'b0, 1'b0);
		far.load(2'h1, 1'b0, 1'b1, 1'b0);
		far.pins(1'b0, 1'b1, 1'b0);
		repeat (8) @(posedge clk_sys);
		#1;
		check(run_o, 1'b1);
		far.pins(1'b1, 1'b0, 1'b0);
		repeat (6) @(posedge clk_sys);
		#1;
		judge(1'b0, 1'b1, 1'b0);
		far.pins(1'b0, 1'b0, 1'b0);
		repeat (6) @(posedge clk_sys);
		#1;
		check(run_o, 1'b1);
		far.load(2'h1, 1'b0, 1'b0, 1'b1);
		far.pins(1'b0, 1'b1, 1'b0);
		repeat (6) @(posedge clk_sys);
		#1;
		judge(1'b0, 1'b1, 1'b0);
		far.pins(1'b0, 1'b0, 1'b0);
		repeat (6) @(posedge clk_sys);
		#1;
		check(run_o, 1'b1);
		far.stop();
		judge(1'b0, 1'b0, 1'b0);
		check(state_o, RSP_ST_STOP);
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial
	begin
		rst_n = 1'b0;
		cart_fitted = 1'b0;
		err_total = 0;
		checks = 0;
		sc_forced();
		sc_keep();
		sc_backup();
		sc_pins();
		summarize();
	end
endmodule
`default_nettype wire
